// ### rtl/ivfr_pkg.sv
// Constants, types and helpers for input voltage fault response.
// Assumes all users share one 16-bit linear-format number encoding.
package ivfr_pkg;
    // Command codes of the four threshold/reaction settings
    localparam logic [7:0]  CMD_OV_WARN  = 8'h57;
    localparam logic [7:0]  CMD_UV_WARN  = 8'h58;
    localparam logic [7:0]  CMD_UV_FAULT = 8'h59;
    localparam logic [7:0]  CMD_UV_REACT = 8'h5A;
    // Reset values of the settings
    // Largest positive linear value, so no overvoltage warning after reset
    localparam logic [15:0] OV_WARN_RST  = 16'h7BFF;
    localparam logic [15:0] UV_WARN_RST  = 16'h0000;
    localparam logic [15:0] UV_FAULT_RST = 16'h0000;
    localparam logic [7:0]  UV_REACT_RST = 8'h00;
    localparam logic [15:0] RD_NONE      = 16'h0000;
    localparam logic [7:0]  RD_PAD       = 8'h00;
    // Response codes, bits 7:6
    localparam logic [1:0]  RESP_IGNORE  = 2'h0;
    localparam logic [1:0]  RESP_DELAY   = 2'h1;
    localparam logic [1:0]  RESP_RETRY   = 2'h2;
    localparam logic [1:0]  RESP_LATCH   = 2'h3;
    // Retry codes, bits 5:3
    localparam logic [2:0]  RETRY_NONE   = 3'h0;
    localparam logic [2:0]  RETRY_ONE    = 3'h1;
    localparam logic [2:0]  RETRY_EVER   = 3'h7;
    // Linear format: 5-bit signed exponent, 11-bit signed mantissa
    localparam int          LIN_MANT_W   = 11;
    localparam int          LIN_VAL_W    = 48;
    localparam logic [5:0]  LIN_EXP_BIAS = 6'h10;

    // Reaction setting, packed in its bit order
    typedef struct packed {
        logic [1:0] resp;     // Response code
        logic [2:0] retries;  // Retry count code
        logic [2:0] delay;    // Delay exponent
    } ivfr_react_t;

    // Status bits shown to the outside
    typedef struct packed {
        logic uv_fault;       // Sticky undervoltage fault
        logic uv_warn;        // Live undervoltage warning
        logic ov_warn;        // Live overvoltage warning
        logic ratio_active;   // Ratio regulation engaged
    } ivfr_status_t;

    // Linear value to a fixed-point number scaled by 2^16
    function automatic logic signed [LIN_VAL_W-1:0] ivfr_lin_value(
        input logic [15:0] lin
    );
        logic signed [LIN_VAL_W-1:0] mant;
        logic        [5:0]           sh;
        mant = LIN_VAL_W'(signed'(lin[LIN_MANT_W-1:0]));
        sh   = {lin[15], lin[15:11]} + LIN_EXP_BIAS;
        return mant <<< sh;
    endfunction : ivfr_lin_value
endpackage : ivfr_pkg

// ### rtl/ivfr_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ps
module ivfr_sync
    import ivfr_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
)(
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_reg;  // First stage, read only by s2
    logic s2_reg;  // Second stage
    logic s3_reg;  // Third stage

    // Shift chain; first stage feeds nothing but the second
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
        end
        else
        begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Accept a change only when stages two and three agree
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            level_out <= RST_VAL;
        else if (s2_reg == s3_reg)
            level_out <= s3_reg;
    end
endmodule : ivfr_sync

// ### rtl/ivfr_delay_timer.sv
// Delay timer: counts 2^exp units of unit_cycles clocks each.
// Assumes unit_cycles is held steady while a count runs.
`timescale 1ns/1ps
module ivfr_delay_timer
    import ivfr_pkg::*;
#(
    parameter int UNIT_W = 16
)(
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic              start,
    input  wire logic [2:0]        exp_sel,
    input  wire logic [UNIT_W-1:0] unit_cycles,
    output logic                   done
);
    logic              busy_reg;   // Count in progress
    logic [UNIT_W-1:0] cyc_reg;    // Clocks inside current unit
    logic [7:0]        units_reg;  // Units elapsed
    logic [7:0]        target_reg; // Units to count
    logic              unit_end;   // Last clock of a unit

    // A zero unit length is taken as one clock, never a hang
    assign unit_end = (cyc_reg + UNIT_W'(1) >= unit_cycles);

    // Counting; a new start always restarts from zero
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            busy_reg   <= 1'b0;
            cyc_reg    <= '0;
            units_reg  <= '0;
            target_reg <= '0;
            done       <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                busy_reg   <= 1'b1;
                cyc_reg    <= '0;
                units_reg  <= '0;
                target_reg <= 8'h01 << exp_sel;
            end
            else if (busy_reg && unit_end)
            begin
                cyc_reg <= '0;
                if (units_reg + 8'h01 == target_reg)
                begin
                    busy_reg <= 1'b0;
                    done     <= 1'b1;
                end
                else
                    units_reg <= units_reg + 8'h01;
            end
            else if (busy_reg)
                cyc_reg <= cyc_reg + UNIT_W'(1);
        end
    end
endmodule : ivfr_delay_timer

// ### rtl/ivfr_top.sv
// Input voltage supervision: thresholds, warnings and the
// undervoltage fault reaction with delay, retry and latch.
// Assumes a command decoder presents writes by command code and
// that the delay unit length arrives from the timing setting.
//
// What this block does
// - Hold writable 16-bit overvoltage warning threshold
// - Hold 16-bit undervoltage warning threshold
// - Undervoltage warning value also sets ratio threshold
// - Ratio mode only when special options enable
// - Hold 16-bit undervoltage fault threshold
// - Response 00: fault never interrupts operation
// - Response 01: run for delay, then retry
// - Response 10: disable at once, then retry
// - Response 11: off until fault cleared
// - Off-then-on command cycle clears latched fault
// - Retry 000: never restart, stay off
// - Retry 001: one restart attempt, then off
// - Retry 010: two restart attempts, then off
// - Restart spacing equals delay count times unit
// - Retry 111: retry until off or shutdown
// - Delay field counts two to its value
// - Delay unit length comes from timing setting
`timescale 1ns/1ps
module ivfr_top
    import ivfr_pkg::*;
#(
    parameter int UNIT_W = 16  // Width of the delay unit count
)(
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic [7:0]        cmd_code,
    input  wire logic              cmd_wr,
    input  wire logic [15:0]       cmd_wdata,
    output logic      [15:0]       cmd_rd_data,
    input  wire logic              clear_faults,
    input  wire logic              uv_fault_bit_clear,
    input  wire logic              operation_on,
    input  wire logic              ctrl_pin,
    input  wire logic              ratio_enable,
    input  wire logic [UNIT_W-1:0] delay_unit_cycles,
    input  wire logic [15:0]       vin_measured,
    output logic                   power_enable,
    output ivfr_status_t           status
);
    // Reaction states
    typedef enum logic [1:0] {
        IVFR_RUN,      // Normal, output allowed
        IVFR_GRACE,    // Running out the delay with fault present
        IVFR_WAIT,     // Output off, waiting for next attempt
        IVFR_LATCHED   // Output off until fault cleared
    } ivfr_state_t;

    logic [15:0]   ov_warn_thr_reg;   // Overvoltage warning limit
    logic [15:0]   uv_warn_thr_reg;   // Undervoltage warn / ratio limit
    logic [15:0]   uv_fault_thr_reg;  // Undervoltage fault limit
    ivfr_react_t   react_reg;         // Fault reaction setting
    ivfr_state_t   state_reg;         // Reaction state
    logic [2:0]    retry_left_reg;    // Attempts still allowed
    logic          timer_start_reg;   // Restart the delay timer
    logic          on_prev_reg;       // Last on request, for edges
    logic          ctrl_level;        // Synchronised control pin
    logic          on_request;        // Host wants output on
    logic          on_rise;           // Off-to-on transition
    logic          clear_evt;         // Any fault clear source
    logic          timer_done;        // Delay expired
    logic          timer_expired;     // Expiry of the run now in progress
    logic          uv_fault_now;      // Input below fault limit
    logic          uv_warn_now;       // Input below warning limit
    logic          ov_warn_now;       // Input above warning limit
    logic          ratio_cond;        // Ratio regulation engaged
    logic signed [LIN_VAL_W-1:0] vin_val;  // Decoded input voltage

    // Control pin comes from outside the clock domain
    ivfr_sync #(
        .RST_VAL   (1'b0)
    ) u_ctrl_sync (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .pin_in    (ctrl_pin),
        .level_out (ctrl_level)
    );

    // Delay and retry spacing timer, unit from timing setting
    ivfr_delay_timer #(
        .UNIT_W      (UNIT_W)
    ) u_timer (
        .ref_clk     (ref_clk),
        .srst        (srst),
        .start       (timer_start_reg),
        .exp_sel     (react_reg.delay),
        .unit_cycles (delay_unit_cycles),
        .done        (timer_done)
    );

    // Output on needs both the pin and the operation command
    assign on_request = operation_on & ctrl_level;
    assign on_rise    = on_request & ~on_prev_reg;
    // An off-then-on cycle clears like the explicit clears
    assign clear_evt  = uv_fault_bit_clear | clear_faults
                      | on_rise;
    // A done pulse from an abandoned run can meet a fresh start;
    // ignoring it there keeps a stale expiry from cutting a delay short
    assign timer_expired = timer_done & ~timer_start_reg;

    // Numeric compares on decoded linear values, not raw codes
    assign vin_val      = ivfr_lin_value(vin_measured);
    assign uv_fault_now = vin_val
                        < ivfr_lin_value(uv_fault_thr_reg);
    assign uv_warn_now  = vin_val
                        < ivfr_lin_value(uv_warn_thr_reg);
    assign ov_warn_now  = vin_val
                        > ivfr_lin_value(ov_warn_thr_reg);
    // One stored value serves warning and ratio threshold
    assign ratio_cond   = ratio_enable & ~uv_warn_now;

    // Threshold and reaction settings written by command code
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ov_warn_thr_reg  <= OV_WARN_RST;
            uv_warn_thr_reg  <= UV_WARN_RST;
            uv_fault_thr_reg <= UV_FAULT_RST;
            react_reg        <= UV_REACT_RST;
        end
        else if (cmd_wr)
        begin
            unique case (cmd_code)
                CMD_OV_WARN:  ov_warn_thr_reg  <= cmd_wdata;
                CMD_UV_WARN:  uv_warn_thr_reg  <= cmd_wdata;
                CMD_UV_FAULT: uv_fault_thr_reg <= cmd_wdata;
                CMD_UV_REACT: react_reg        <= cmd_wdata[7:0];
                default: ;  // Other codes belong elsewhere
            endcase
        end
    end

    // Read-back mux, registered; unknown codes answer zero
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            cmd_rd_data <= RD_NONE;
        else
        begin
            unique case (cmd_code)
                CMD_OV_WARN:  cmd_rd_data <= ov_warn_thr_reg;
                CMD_UV_WARN:  cmd_rd_data <= uv_warn_thr_reg;
                CMD_UV_FAULT: cmd_rd_data <= uv_fault_thr_reg;
                CMD_UV_REACT: cmd_rd_data <= {RD_PAD, react_reg};
                default:      cmd_rd_data <= RD_NONE;
            endcase
        end
    end

    // Edge memory for the on request
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            on_prev_reg <= 1'b0;
        else
            on_prev_reg <= on_request;
    end

    // Reaction sequencer. An off command halts any retry run,
    // including the endless one, and parks the machine in RUN.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_reg       <= IVFR_RUN;
            retry_left_reg  <= RETRY_NONE;
            timer_start_reg <= 1'b0;
        end
        else
        begin
            timer_start_reg <= 1'b0;
            if (!on_request)
                state_reg <= IVFR_RUN;
            else
            begin
                unique case (state_reg)
                    IVFR_RUN:
                    begin
                        if (uv_fault_now)
                        begin
                            unique case (react_reg.resp)
                                RESP_IGNORE: ;
                                RESP_DELAY:
                                begin
                                    state_reg       <= IVFR_GRACE;
                                    timer_start_reg <= 1'b1;
                                end
                                RESP_RETRY:
                                begin
                                    if (react_reg.retries == RETRY_NONE)
                                        state_reg <= IVFR_LATCHED;
                                    else
                                    begin
                                        state_reg       <= IVFR_WAIT;
                                        timer_start_reg <= 1'b1;
                                        retry_left_reg  <= react_reg.retries;
                                    end
                                end
                                RESP_LATCH:
                                    state_reg <= IVFR_LATCHED;
                            endcase
                        end
                    end
                    IVFR_GRACE:
                    begin
                        // Fault gone inside the delay: carry on
                        if (!uv_fault_now)
                            state_reg <= IVFR_RUN;
                        else if (timer_expired)
                        begin
                            if (react_reg.retries == RETRY_NONE)
                                state_reg <= IVFR_LATCHED;
                            else
                            begin
                                state_reg       <= IVFR_WAIT;
                                timer_start_reg <= 1'b1;
                                retry_left_reg  <= react_reg.retries;
                            end
                        end
                    end
                    IVFR_WAIT:
                    begin
                        // Restart attempt at each timer expiry
                        if (timer_expired)
                        begin
                            if (!uv_fault_now)
                                state_reg <= IVFR_RUN;
                            else if (react_reg.retries == RETRY_EVER)
                                timer_start_reg <= 1'b1;
                            else if (retry_left_reg == RETRY_ONE)
                                state_reg <= IVFR_LATCHED;
                            else
                            begin
                                retry_left_reg  <= retry_left_reg - 3'h1;
                                timer_start_reg <= 1'b1;
                            end
                        end
                    end
                    IVFR_LATCHED:
                    begin
                        if (clear_evt)
                            state_reg <= IVFR_RUN;
                    end
                endcase
            end
        end
    end

    // Output drive: only RUN and GRACE may supply power
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            power_enable <= 1'b0;
        else
            power_enable <= on_request
                          & ((state_reg == IVFR_RUN)
                          | (state_reg == IVFR_GRACE));
    end

    // Status flags. Fault flag is sticky and a new fault in the
    // clear cycle wins, so no event is lost.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            status <= '0;
        else
        begin
            status.uv_warn      <= uv_warn_now;
            status.ov_warn      <= ov_warn_now;
            status.ratio_active <= ratio_cond;
            if (uv_fault_now)
                status.uv_fault <= 1'b1;
            else if (clear_evt)
                status.uv_fault <= 1'b0;
        end
    end

    // Entry into a disable-and-retry reaction
    sequence s_retry_entry;
        state_reg == IVFR_RUN && uv_fault_now && on_request
        && react_reg.resp == RESP_RETRY
        && react_reg.retries != RETRY_NONE;
    endsequence
    // A failed attempt under a finite retry count, any number remaining
    sequence s_failed_attempt;
        state_reg == IVFR_WAIT && timer_expired && uv_fault_now
        && on_request && react_reg.retries != RETRY_EVER;
    endsequence

    AST_OV_WRITE: assert property (@(posedge ref_clk) disable iff (srst)
        cmd_wr && cmd_code == CMD_OV_WARN |=> ov_warn_thr_reg == $past(cmd_wdata))
        else $error("overvoltage warning limit not stored");
    AST_UV_WARN_WRITE: assert property (@(posedge ref_clk) disable iff (srst)
        cmd_wr && cmd_code == CMD_UV_WARN |=> ##1 $past(cmd_code) != CMD_UV_WARN
        || cmd_rd_data == $past(cmd_wdata, 2))
        else $error("undervoltage warning limit not read back");
    AST_RATIO_THR: assert property (@(posedge ref_clk) disable iff (srst)
        ratio_enable && vin_val < ivfr_lin_value(uv_warn_thr_reg)
        |=> !status.ratio_active && status.uv_warn)
        else $error("ratio threshold differs from warning limit");
    AST_RATIO_GATE: assert property (@(posedge ref_clk) disable iff (srst)
        !ratio_enable |=> !status.ratio_active)
        else $error("ratio mode active while disabled");
    AST_UVF_WRITE: assert property (@(posedge ref_clk) disable iff (srst)
        cmd_wr && cmd_code == CMD_UV_FAULT |=> uv_fault_thr_reg == $past(cmd_wdata))
        else $error("undervoltage fault limit not stored");
    AST_IGNORE: assert property (@(posedge ref_clk) disable iff (srst)
        state_reg == IVFR_RUN && react_reg.resp == RESP_IGNORE && on_request
        |=> state_reg == IVFR_RUN ##1 power_enable || !$past(on_request))
        else $error("ignored fault interrupted operation");
    AST_GRACE: assert property (@(posedge ref_clk) disable iff (srst)
        state_reg == IVFR_RUN && uv_fault_now && on_request
        && react_reg.resp == RESP_DELAY |=> state_reg == IVFR_GRACE && timer_start_reg)
        else $error("delayed response did not start its delay");
    AST_DISABLE: assert property (@(posedge ref_clk) disable iff (srst)
        s_retry_entry |=> state_reg == IVFR_WAIT ##1 !power_enable)
        else $error("disable response left output on");
    AST_LATCH_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
        state_reg == IVFR_LATCHED && !clear_evt && on_request |=> state_reg == IVFR_LATCHED)
        else $error("latched fault released without a clear");
    AST_NO_RETRY: assert property (@(posedge ref_clk) disable iff (srst)
        state_reg == IVFR_RUN && uv_fault_now && on_request && react_reg.resp == RESP_RETRY
        && react_reg.retries == RETRY_NONE |=> state_reg == IVFR_LATCHED)
        else $error("retry attempted with zero retries");
    AST_LAST_TRY: assert property (@(posedge ref_clk) disable iff (srst)
        s_failed_attempt and retry_left_reg == RETRY_ONE |=> state_reg == IVFR_LATCHED)
        else $error("last failed attempt did not latch");
    AST_CONSUME: assert property (@(posedge ref_clk) disable iff (srst)
        s_failed_attempt and retry_left_reg > RETRY_ONE
        |=> retry_left_reg == $past(retry_left_reg) - 3'h1 && timer_start_reg)
        else $error("failed attempt did not consume a retry");
    AST_FOREVER: assert property (@(posedge ref_clk) disable iff (srst)
        state_reg == IVFR_WAIT && timer_expired && uv_fault_now && on_request
        && react_reg.retries == RETRY_EVER |=> state_reg == IVFR_WAIT && timer_start_reg)
        else $error("endless retry stopped");
    AST_FLAG: assert property (@(posedge ref_clk) disable iff (srst)
        uv_fault_now |=> status.uv_fault)
        else $error("undervoltage fault not flagged");
endmodule : ivfr_top

// ### testbench/ivfr_host.sv
// Host stand-in that writes and reads back the voltage settings.
// Assumes the device samples commands on the rising edge of ref_clk.
`timescale 1ns/1ps
module ivfr_host
    import ivfr_pkg::*;
(
    input  wire logic        ref_clk,
    output logic      [7:0]  cmd_code,
    output logic             cmd_wr,
    output logic      [15:0] cmd_wdata,
    input  wire logic [15:0] cmd_rd_data
);
    // Idle bus at time zero
    initial
    begin
        cmd_code  = 8'h00;
        cmd_wr    = 1'b0;
        cmd_wdata = 16'h0000;
    end
    // One-cycle strobe, launched off the falling edge
    task automatic write(input logic [7:0] c, input logic [15:0] d);
        @(negedge ref_clk);
        cmd_code  = c;
        cmd_wdata = d;
        cmd_wr    = 1'b1;
        @(negedge ref_clk);
        cmd_wr    = 1'b0;
        cmd_wdata = ~d; // Stale data must not linger
    endtask : write
    // Read-back is registered, so wait one edge past the code change
    task automatic read(input logic [7:0] c, output logic [15:0] d);
        @(negedge ref_clk);
        cmd_code = c;
        @(negedge ref_clk);
        d = cmd_rd_data;
    endtask : read
endmodule : ivfr_host

// ### testbench/test_input_voltage_fault_response.sv
// Bench for thresholds, warnings and the undervoltage reaction.
// Assumes the host stand-in owns the command port.
`timescale 1ns/1ps
module test_input_voltage_fault_response;
    import ivfr_pkg::*;
    logic         ref_clk, srst, clr, bclr, op_on, ctl, rat_en, cmd_wr, power_enable;
    logic [15:0]  unit, vin, rd, lfsr, cmd_wdata, cmd_rd_data;
    logic [7:0]   cmd_code;
    ivfr_status_t status;
    int           err_count, tests_run, n, mdl[int]; // Model holds settings by code
    // Free-running 20 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    ivfr_host i_ivfr_host (.ref_clk(ref_clk), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
        .cmd_wdata(cmd_wdata), .cmd_rd_data(cmd_rd_data));
    ivfr_top #(.UNIT_W(16)) i_ivfr_top (.ref_clk(ref_clk), .srst(srst), .cmd_code(cmd_code),
        .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .cmd_rd_data(cmd_rd_data),
        .clear_faults(clr), .uv_fault_bit_clear(bclr), .operation_on(op_on), .ctrl_pin(ctl),
        .ratio_enable(rat_en), .delay_unit_cycles(unit), .vin_measured(vin),
        .power_enable(power_enable), .status(status));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (s !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask : cyc
    // Write through the host and mirror it; unmapped codes are dropped
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        i_ivfr_host.write(c, d);
        if (mdl.exists(c))
            mdl[c] = (c == CMD_UV_REACT) ? d[7:0] : d;
    endtask : wr
    task automatic rdchk(input logic [7:0] c);
        i_ivfr_host.read(c, rd);
        chk("read_back", mdl.exists(c) ? 16'(mdl[c]) : RD_NONE, rd);
    endtask : rdchk
    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : step
    task automatic complete_run;
        if (err_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // Watchdog sized well past the expected run of a few hundred cycles
    initial
    begin
        #(50 * 2000);
        err_count++;
        complete_run();
    end
    initial
    begin
        {srst, clr, bclr, op_on, ctl, rat_en} = 6'b100000;
        unit = 16'h0001;
        vin = 16'h0078;
        lfsr = 16'h6D32;
        mdl = '{8'h57: OV_WARN_RST, 8'h58: UV_WARN_RST, 8'h59: UV_FAULT_RST, 8'h5A: UV_REACT_RST};
        cyc(6);
        srst = 1'b0;
        // Reset values, then random contents; 0x5B stays unmapped
        for (int p = 0; p < 2; p++)
            for (int c = 8'h57; c <= 8'h5B; c++)
            begin
                rdchk(8'(c));
                lfsr = step(lfsr);
                wr(8'(c), lfsr);
            end
        wr(CMD_OV_WARN, 16'h00C8);
        wr(CMD_UV_WARN, 16'h0064);
        wr(CMD_UV_FAULT, 16'h0050);
        wr(CMD_UV_REACT, 16'h0000);
        {op_on, ctl} = 2'b11;
        cyc(12);
        rat_en = 1'b1;
        cyc(3);
        chk("power_status", 5'b10001, {power_enable, status});
        vin = 16'h00D2;
        cyc(3);
        chk("status", 4'b0011, status);
        // Ignored fault, cleared both ways
        for (int k = 0; k < 2; k++)
        begin
            vin = 16'h0040;
            cyc(4);
            chk("power_status", 5'b11100, {power_enable, status});
            vin = 16'h0078;
            cyc(3);
            {clr, bclr} = (k == 0) ? 2'b10 : 2'b01;
            cyc(1);
            {clr, bclr} = 2'b00;
            cyc(3);
            chk("power_status", 5'b10001, {power_enable, status});
        end
        wr(CMD_UV_REACT, 16'h0080);
        vin = 16'h0040;
        cyc(4);
        chk("power_enable", 0, power_enable);
        vin = 16'h0078;
        cyc(20);
        chk("power_enable", 0, power_enable);
        op_on = 1'b0;
        cyc(3);
        op_on = 1'b1;
        cyc(6);
        chk("power_status", 5'b10001, {power_enable, status});
        // Latch until an individual clear, fault gone meanwhile
        wr(CMD_UV_REACT, 16'h00C0);
        vin = 16'h0040;
        cyc(4);
        vin = 16'h0078;
        cyc(8);
        chk("power_enable", 0, power_enable);
        bclr = 1'b1;
        cyc(1);
        bclr = 1'b0;
        cyc(3);
        chk("power_enable", 1, power_enable);
        // Two retries, four-clock unit: first attempt fails, second resumes
        unit = 16'h0004;
        wr(CMD_UV_REACT, 16'h0090);
        vin = 16'h0040;
        cyc(9);
        vin = 16'h0078;
        cyc(8);
        chk("power_enable", 1, power_enable);
        // Both attempts fail, so the output stays off until cleared
        vin = 16'h0040;
        cyc(20);
        vin = 16'h0078;
        cyc(4);
        chk("power_enable", 0, power_enable);
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(3);
        chk("power_enable", 1, power_enable);
        // Endless retry resumes once the fault goes away
        wr(CMD_UV_REACT, 16'h00B8);
        vin = 16'h0040;
        cyc(40);
        chk("power_enable", 0, power_enable);
        vin = 16'h0078;
        cyc(10);
        chk("power_enable", 1, power_enable);
        // One retry, four units of two clocks between attempts
        wr(CMD_UV_REACT, 16'h008A);
        unit = 16'h0002;
        vin = 16'h0040;
        cyc(2);
        vin = 16'h0078;
        n = 0;
        repeat (40)
        begin
            cyc(1);
            n += !power_enable;
        end
        chk("off_span", 1, n >= 8 && n <= 14);
        wr(CMD_UV_REACT, 16'h0040);
        unit = 16'h0004;
        vin = 16'h0040;
        cyc(2);
        chk("power_enable", 1, power_enable);
        cyc(10);
        chk("power_enable", 0, power_enable);
        complete_run();
    end
endmodule : test_input_voltage_fault_response
